/* bench/xpd_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Core side issuing extension-bus accesses
module xpd_cpu_model (
    input  wire logic        mclk,
    output var  logic        cpuReq,
    output var  logic [23:0] cpuAddr
);
    // Idle state before any access
    initial begin
        cpuReq = 1'b0;
        cpuAddr = 24'hFFFFFF;
    end

    // One access after an optional delay, address scrambled once released
    task automatic access(input logic [23:0] a, input int gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        cpuReq <= 1'b1;
        cpuAddr <= a;
        @(posedge mclk);
        cpuReq <= 1'b0;
        cpuAddr <= ~a;
    endtask
endmodule

`default_nettype wire

/* bench/xpd_periph_enable_asserts.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Port checks of the register bus timing, window decode and pin release
module xpd_periph_enable_asserts (
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        clkEn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        cpuReq,
    input wire logic [23:0] cpuAddr,
    input wire logic        routeValid,
    input wire logic [6:0]  routeSel,
    input wire logic [4:0]  periphActive,
    input wire logic [3:0]  portFree
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    // Bus transfer steps
    sequence rd_take;
        hsel && htrans[1] && !hwrite && hready && clkEn;
    endsequence
    sequence wr_take;
        hsel && htrans[1] && hwrite && hready && clkEn;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    // Register bus timing
    read_wait_once_a: assert property (rd_take |=> one_wait)
        else $error("read wait not one cycle");
    write_no_wait_a: assert property (wr_take |=> hreadyout)
        else $error("write stalled");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");

    // Routing relations
    route_follows_req_a: assert property (clkEn |=> routeValid == $past(cpuReq))
        else $error("route strobe not one cycle after request");
    route_one_hot_a: assert property (routeValid ? $onehot0(routeSel) : routeSel == 7'h00)
        else $error("route select not one hot");
    unit_needs_active_a: assert property ((routeSel[4:0] & ~periphActive) == 5'h00)
        else $error("inactive unit selected");
    shared_external_a: assert property (routeSel[5] && $past(cpuAddr[23:10]) == 14'h03B
        |-> (periphActive & 5'h13) == 5'h00)
        else $error("shared window external while unit active");
    ram_route_a: assert property (routeValid && $past(cpuAddr[23:14]) == 10'h002
        |-> routeSel == (periphActive[2] ? 7'h04 : 7'h20))
        else $error("ram window misrouted");
    group_route_a: assert property (routeValid && $past(cpuAddr[23:10]) == 14'h030
        |-> routeSel == (periphActive[3] ? 7'h08 : 7'h20))
        else $error("group window misrouted");
    port_free_a: assert property (portFree == {~periphActive[1], ~periphActive[0],
        ~periphActive[0], ~periphActive[1]})
        else $error("pin release wrong");
endmodule

`default_nettype wire

/* bench/xpd_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "xpd_map.vh"

// ==========================================================
// Top bench
module testbench;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        clkEn = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         cpuReq;
    wire  [23:0] cpuAddr;
    wire         routeValid;
    wire  [6:0]  routeSel;
    wire  [4:0]  periphActive;
    wire  [3:0]  portFree;
    int          err_count = 0;
    int          comparisons = 0;
    logic [31:0] rd;
    logic [8:0]  rows [6] = '{{5'h00, 4'hF}, {5'h05, 4'h9}, {5'h1F, 4'h0},
                              {5'h10, 4'hF}, {5'h02, 4'h6}, {5'h08, 4'hF}};
    logic [23:0] addrs [7] = '{24'h008010, 24'h00C010, 24'h00EC10, 24'h00ED10,
                               24'h00EE10, 24'h00EF10, 24'h001000};

    always #5 mclk = ~mclk;

    xpd_periph_enable dut (.mclk(mclk), .arst_n(arst_n), .clkEn(clkEn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpuReq(cpuReq), .cpuAddr(cpuAddr), .routeValid(routeValid), .routeSel(routeSel),
        .periphActive(periphActive), .portFree(portFree));
    xpd_cpu_model cpu (.mclk(mclk), .cpuReq(cpuReq), .cpuAddr(cpuAddr));

    // Verdict and end of run
    task close_out;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // Single AHB-Lite transfer
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        hsel <= 1'b0;
    endtask

    task do_reset;
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
    endtask

    function automatic logic [6:0] exp_route(input logic [4:0] v, input logic [23:0] a);
        if (a inside {[24'h008000:24'h00BFFF]}) return v[2] ? 7'h04 : 7'h20;
        if (a inside {[24'h00C000:24'h00C3FF]}) return v[3] ? 7'h08 : 7'h20;
        if (!(a inside {[24'h00EC00:24'h00EFFF]})) return 7'h00;
        if ((v & 5'h13) == 5'h00) return 7'h20;
        if (a[15:8] == 8'hEC && v[4]) return 7'h10;
        if (a[15:8] == 8'hEE && v[1]) return 7'h02;
        if (a[15:8] == 8'hEF && v[0]) return 7'h01;
        return 7'h40;
    endfunction

    // Every test address against the expected target
    task run_routes(input logic [4:0] v);
        foreach (addrs[i]) begin
            cpu.access(addrs[i], i % 2);
            #1;
            chk("routeSel", 32'(exp_route(v, addrs[i])), 32'(routeSel));
            chk("routeValid", 32'h1, 32'(routeValid));
        end
    endtask

    // Watchdog
    initial begin
        #50000;
        err_count++;
        close_out;
    end

    // Main sequence
    initial begin
        do_reset;
        chk("portFree", 32'hF, 32'(portFree));
        ahb(1'b0, `XPD_OFF_SELECT, 32'h0);
        chk("select", 32'h5, rd);
        run_routes(5'h00);
        foreach (rows[i]) begin
            do_reset;
            ahb(1'b1, `XPD_OFF_SELECT, 32'(rows[i][8:4]));
            ahb(1'b0, `XPD_OFF_SELECT, 32'h0);
            chk("select", 32'(rows[i][8:4]), rd);
            ahb(1'b1, `XPD_OFF_SYSCFG, 32'h4);
            repeat (2) @(posedge mclk);
            #1;
            chk("periphActive", 32'(rows[i][8:4]), 32'(periphActive));
            chk("portFree", 32'(rows[i][3:0]), 32'(portFree));
            run_routes(rows[i][8:4]);
        end
        // Locked select ignores writes, also after global clear
        ahb(1'b1, `XPD_OFF_SELECT, 32'h1F);
        ahb(1'b0, `XPD_OFF_SELECT, 32'h0);
        chk("select", 32'h08, rd);
        ahb(1'b0, `XPD_OFF_STATUS, 32'h0);
        chk("status", 32'hF68, rd);
        run_routes(5'h08);
        ahb(1'b1, `XPD_OFF_SYSCFG, 32'h0);
        ahb(1'b1, `XPD_OFF_SELECT, 32'h1F);
        ahb(1'b0, `XPD_OFF_SELECT, 32'h0);
        chk("select", 32'h08, rd);
        chk("periphActive", 32'h0, 32'(periphActive));
        // Clock enable low freezes the routing register
        @(posedge mclk);
        clkEn <= 1'b0;
        cpu.access(24'h00EF10, 0);
        #1;
        chk("frozenRoute", 32'h0, 32'(routeValid));
        @(posedge mclk);
        clkEn <= 1'b1;
        ahb(1'b0, 32'h0000F010, 32'h0);
        chk("unmapped", 32'h0, rd);
        close_out;
    end
endmodule

bind xpd_periph_enable xpd_periph_enable_asserts chk_i (.mclk, .arst_n, .clkEn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hresp, .cpuReq, .cpuAddr, .routeValid, .routeSel,
    .periphActive, .portFree);

`default_nettype wire

/* hdl/xpd_ahb_port.v */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// AHB-Lite slave front end: writes zero wait, reads one wait
module xpd_ahb_port (
    input  wire        mclk,
    input  wire        arst_n,
    input  wire        clkEn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire        hready,
    output reg         wrPend_reg,
    output reg         rdPend_reg,
    output reg  [15:0] regAddr_reg,
    output reg         hreadyout_reg
);

    // Address phase capture and data phase tracking
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend_reg    <= 1'b0;
            rdPend_reg    <= 1'b0;
            regAddr_reg   <= 16'h0000;
            hreadyout_reg <= 1'b1;
        end else if (clkEn) begin
            wrPend_reg <= 1'b0;
            if (rdPend_reg) begin
                rdPend_reg    <= 1'b0;
                hreadyout_reg <= 1'b1;
            end else if (hsel && htrans[1] && hready) begin
                regAddr_reg   <= haddr[15:0];
                wrPend_reg    <= hwrite;
                rdPend_reg    <= ~hwrite;
                hreadyout_reg <= hwrite;  // Read inserts one wait
            end
        end
    end

endmodule
`default_nettype wire

/* hdl/xpd_map.vh */
`ifndef XPD_MAP_VH
`define XPD_MAP_VH

// ==========================================================
// Register byte offsets
`define XPD_OFF_SYSCFG   16'hF000
`define XPD_OFF_SELECT   16'hF024
`define XPD_OFF_STATUS   16'hF02C

// ==========================================================
// Reset values
`define XPD_SELECT_RST   5'h05
`define XPD_GLOBAL_RST   1'b0

// ==========================================================
// Field positions
`define XPD_SEL_W        5
`define XPD_BIT_FIRST_CAN_CTRL     0
`define XPD_BIT_SECOND_CAN_CTRL     1
`define XPD_BIT_EXTENSION_RAM     2
`define XPD_BIT_GRP      3
`define XPD_BIT_PWM      4
`define XPD_BIT_GLOBAL   2
`define XPD_STAT_LOCK    5
`define XPD_STAT_IGN     6
`define XPD_STAT_FREE    8

// ==========================================================
// Route encoding, one bit per target
`define XPD_RT_W         7
`define XPD_RT_FIRST_CAN_CTRL      0
`define XPD_RT_SECOND_CAN_CTRL      1
`define XPD_RT_EXTENSION_RAM      2
`define XPD_RT_GRP       3
`define XPD_RT_PWM       4
`define XPD_RT_EXT       5
`define XPD_RT_BLOCK     6

// ==========================================================
// Address windows
`define XPD_EXTENSION_RAM_LO      24'h008000
`define XPD_EXTENSION_RAM_HI      24'h00BFFF
`define XPD_GRP_LO       24'h00C000
`define XPD_GRP_HI       24'h00C3FF
`define XPD_PWM_LO       24'h00EC00
`define XPD_PWM_HI       24'h00ECFF
`define XPD_SECOND_CAN_CTRL_LO      24'h00EE00
`define XPD_SECOND_CAN_CTRL_HI      24'h00EEFF
`define XPD_FIRST_CAN_CTRL_LO      24'h00EF00
`define XPD_FIRST_CAN_CTRL_HI      24'h00EFFF
`define XPD_XBLK_LO      24'h00EC00
`define XPD_XBLK_HI      24'h00EFFF

`endif

/* hdl/xpd_periph_enable.v */
`timescale 1ns/100ps
`default_nettype none
`include "xpd_map.vh"

// Functional notes
// R1: A deselected unit takes no address range, pins or interrupts once enabled.
// R2: Select register at F024h holds five enable bits, bits above read zero.
// R3: First CAN blocked and its two pins freed when its bit is clear.
// R4: First CAN window goes external only if both CANs and PWM are off.
// R5: Second CAN blocked and its two pins freed when its bit is clear.
// R6: Second CAN window goes external only if both CANs and PWM are off.
// R7: Extension RAM off means its accesses are performed externally.
// R8: Timer, port and mux group off means external accesses.
// R9: PWM off is inaccessible, its window external only if both CANs off.
// R10: All three off sends the whole shared window to external memory.
// R11: Select register resets to 05h.
// R12: After the global enable is set the select register never changes.
// R13: A unit is active only when global enable and its own bit are set.
// R14: Select writes after global enable are silently dropped; the code drops them but sets the ignored flag in status bit 6.
module xpd_periph_enable (
    input  wire                  mclk,
    input  wire                  arst_n,
    input  wire                  clkEn,
    input  wire                  hsel,
    input  wire [31:0]           haddr,
    input  wire [1:0]            htrans,
    input  wire                  hwrite,
    input  wire [2:0]            hsize,
    input  wire [31:0]           hwdata,
    input  wire                  hready,
    output wire [31:0]           hrdata,
    output wire                  hreadyout,
    output wire                  hresp,
    input  wire                  cpuReq,
    input  wire [23:0]           cpuAddr,
    output wire                  routeValid,
    output wire [`XPD_RT_W-1:0]  routeSel,
    output wire [4:0]            periphActive,
    output wire [3:0]            portFree
);

    // ==========================================================
    // Lock state machine
    localparam [1:0] ST_OPEN   = 2'b01;
    localparam [1:0] ST_LOCKED = 2'b10;

    // Word indices of the mapped registers, cut to the decoded width
    localparam [15:0] OFF_SYS = `XPD_OFF_SYSCFG;
    localparam [15:0] OFF_SEL = `XPD_OFF_SELECT;
    localparam [15:0] OFF_STA = `XPD_OFF_STATUS;
    localparam [13:0] IDX_SYS = OFF_SYS[15:2];
    localparam [13:0] IDX_SEL = OFF_SEL[15:2];
    localparam [13:0] IDX_STA = OFF_STA[15:2];

    // ==========================================================
    // Declarations
    reg  [1:0]            state_reg;
    reg  [1:0]            state_next;
    reg                   global_reg;
    reg  [4:0]            select_reg;
    reg  [4:0]            select_next;
    reg                   ignored_reg;
    reg                   ignored_next;
    reg  [31:0]           hrdata_reg;
    reg  [31:0]           rdMux;
    reg                   hresp_reg;
    reg  [4:0]            active_reg;
    reg  [3:0]            portFree_reg;
    wire [4:0]            activeNow;
    wire                  wrPend;
    wire                  rdPend;
    wire [15:0]           regAddr;
    wire                  wrSysCfg;
    wire                  wrSelect;
    wire                  rdStatus;
    wire                  frozen;

    // ==========================================================
    // Bus front end
    xpd_ahb_port u_port (
        .mclk          (mclk),
        .arst_n        (arst_n),
        .clkEn         (clkEn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hready        (hready),
        .wrPend_reg    (wrPend),
        .rdPend_reg    (rdPend),
        .regAddr_reg   (regAddr),
        .hreadyout_reg (hreadyout)
    );

    // Write and read strobes per register
    assign wrSysCfg = wrPend && (regAddr[15:2] == IDX_SYS);
    assign wrSelect = wrPend && (regAddr[15:2] == IDX_SEL);
    assign rdStatus = rdPend && (regAddr[15:2] == IDX_STA);

    // Select is frozen as soon as global enable is seen
    assign frozen = (state_reg == ST_LOCKED) || global_reg;  // see R12

    // ==========================================================
    // Lock state: leaves open once, only reset returns
    always @* begin
        case (state_reg)
            ST_OPEN: begin
                if (global_reg) begin
                    state_next = ST_LOCKED;
                end else begin
                    state_next = ST_OPEN;
                end
            end
            ST_LOCKED: begin
                state_next = ST_LOCKED;
            end
            default: begin
                state_next = ST_LOCKED;
            end
        endcase
    end

    // ==========================================================
    // Select register next value
    always @* begin
        select_next  = select_reg;
        ignored_next = ignored_reg;
        if (rdStatus) begin
            ignored_next = 1'b0;  // Flag clears when status is read
        end
        if (wrSelect) begin
            if (frozen) begin
                ignored_next = 1'b1;  // see R14
            end else begin
                select_next = hwdata[4:0];  // see R2
            end
        end
    end

    // ==========================================================
    // Configuration registers
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg   <= ST_OPEN;
            global_reg  <= `XPD_GLOBAL_RST;
            select_reg  <= `XPD_SELECT_RST;  // see R11
            ignored_reg <= 1'b0;
        end else if (clkEn) begin
            state_reg   <= state_next;
            select_reg  <= select_next;  // see R12
            ignored_reg <= ignored_next;
            if (wrSysCfg) begin
                global_reg <= hwdata[`XPD_BIT_GLOBAL];
            end
        end
    end

    // ==========================================================
    // Per-unit activity from global enable and select bit
    genvar gi;
    generate
        for (gi = 0; gi < `XPD_SEL_W; gi = gi + 1) begin : g_act
            assign activeNow[gi] = global_reg & select_reg[gi];  // see R13
        end
    endgenerate

    // ==========================================================
    // Activity and pin release outputs
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            active_reg   <= 5'h00;
            portFree_reg <= 4'hF;
        end else if (clkEn) begin
            active_reg <= activeNow;  // see R1
            // Index 0..3 stands for port pins 4.4 to 4.7
            portFree_reg[0] <= ~activeNow[`XPD_BIT_SECOND_CAN_CTRL];  // see R5
            portFree_reg[1] <= ~activeNow[`XPD_BIT_FIRST_CAN_CTRL];  // see R3
            portFree_reg[2] <= ~activeNow[`XPD_BIT_FIRST_CAN_CTRL];  // see R3
            portFree_reg[3] <= ~activeNow[`XPD_BIT_SECOND_CAN_CTRL];  // see R5
        end
    end

    // ==========================================================
    // Access routing
    xpd_window_decode u_dec (
        .mclk           (mclk),
        .arst_n         (arst_n),
        .clkEn          (clkEn),
        .reqValid       (cpuReq),
        .reqAddr        (cpuAddr),
        .active         (activeNow),
        .routeValid_reg (routeValid),
        .routeSel_reg   (routeSel)
    );

    // ==========================================================
    // Read data mux, unmapped offsets read zero
    always @* begin
        rdMux = 32'h00000000;
        case (regAddr[15:2])
            IDX_SYS: begin
                rdMux[`XPD_BIT_GLOBAL] = global_reg;
            end
            IDX_SEL: begin
                rdMux[4:0] = select_reg;  // see R2
            end
            IDX_STA: begin
                rdMux[4:0] = activeNow;
                rdMux[`XPD_STAT_LOCK] = frozen;
                rdMux[`XPD_STAT_IGN] = ignored_reg;
                rdMux[`XPD_STAT_FREE +: 4] = portFree_reg;
            end
            default: begin
                rdMux = 32'h00000000;
            end
        endcase
    end

    // Read data and response registers
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hrdata_reg <= 32'h00000000;
            hresp_reg  <= 1'b0;
        end else if (clkEn) begin
            hresp_reg <= 1'b0;  // Always OKAY
            if (rdPend) begin
                hrdata_reg <= rdMux;
            end
        end
    end

    // ==========================================================
    // Output drive
    assign hrdata       = hrdata_reg;
    assign hresp        = hresp_reg;
    assign periphActive = active_reg;
    assign portFree     = portFree_reg;

endmodule
`default_nettype wire

/* hdl/xpd_window_decode.v */
`timescale 1ns/100ps
`default_nettype none
`include "xpd_map.vh"

// ==========================================================
// Registered routing of one extension-bus access
module xpd_window_decode (
    input  wire                  mclk,
    input  wire                  arst_n,
    input  wire                  clkEn,
    input  wire                  reqValid,
    input  wire [23:0]           reqAddr,
    input  wire [4:0]            active,
    output reg                   routeValid_reg,
    output reg  [`XPD_RT_W-1:0]  routeSel_reg
);

    reg [`XPD_RT_W-1:0] routeSel_next;
    reg                 inCan1;
    reg                 inCan2;
    reg                 inPwm;
    reg                 inXram;
    reg                 inGrp;
    reg                 inXblk;
    reg                 blkAll;

    // Window match and target choice
    always @* begin
        inCan1 = (reqAddr >= `XPD_FIRST_CAN_CTRL_LO) && (reqAddr <= `XPD_FIRST_CAN_CTRL_HI);
        inCan2 = (reqAddr >= `XPD_SECOND_CAN_CTRL_LO) && (reqAddr <= `XPD_SECOND_CAN_CTRL_HI);
        inPwm  = (reqAddr >= `XPD_PWM_LO) && (reqAddr <= `XPD_PWM_HI);
        inXram = (reqAddr >= `XPD_EXTENSION_RAM_LO) && (reqAddr <= `XPD_EXTENSION_RAM_HI);
        inGrp  = (reqAddr >= `XPD_GRP_LO) && (reqAddr <= `XPD_GRP_HI);
        inXblk = (reqAddr >= `XPD_XBLK_LO) && (reqAddr <= `XPD_XBLK_HI);
        blkAll = ~active[`XPD_BIT_FIRST_CAN_CTRL] & ~active[`XPD_BIT_SECOND_CAN_CTRL]
               & ~active[`XPD_BIT_PWM];  // see R10
        routeSel_next = {`XPD_RT_W{1'b0}};
        routeSel_next[`XPD_RT_FIRST_CAN_CTRL] = inCan1 & active[`XPD_BIT_FIRST_CAN_CTRL];  // see R3
        routeSel_next[`XPD_RT_SECOND_CAN_CTRL] = inCan2 & active[`XPD_BIT_SECOND_CAN_CTRL];  // see R5
        routeSel_next[`XPD_RT_PWM]  = inPwm & active[`XPD_BIT_PWM];    // see R9
        routeSel_next[`XPD_RT_EXTENSION_RAM] = inXram & active[`XPD_BIT_EXTENSION_RAM];  // see R7
        routeSel_next[`XPD_RT_GRP]  = inGrp & active[`XPD_BIT_GRP];    // see R8
        // External only for disabled units, shared window only if all off
        routeSel_next[`XPD_RT_EXT]  = (inXram & ~active[`XPD_BIT_EXTENSION_RAM])
                                    | (inGrp & ~active[`XPD_BIT_GRP])
                                    | (inXblk & blkAll);  // see R4, see R6
        // Inside the shared window but nobody may answer
        routeSel_next[`XPD_RT_BLOCK] = inXblk & ~blkAll
                                     & ~routeSel_next[`XPD_RT_FIRST_CAN_CTRL]
                                     & ~routeSel_next[`XPD_RT_SECOND_CAN_CTRL]
                                     & ~routeSel_next[`XPD_RT_PWM];  // see R1
    end

    // Route register
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            routeValid_reg <= 1'b0;
            routeSel_reg   <= {`XPD_RT_W{1'b0}};
        end else if (clkEn) begin
            routeValid_reg <= reqValid;
            routeSel_reg   <= reqValid ? routeSel_next : {`XPD_RT_W{1'b0}};
        end
    end

endmodule
`default_nettype wire
